// ---- src/dcp_chan_front.sv ----
`timescale 1ns/1ps
`include "dcp_map.svh"

module dcp_chan_front (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Presence pin and sample strobe
    input wire logic pres_i,
    input wire logic tick_i,
    // Accumulated counts
    output dcp_pkg::dcp_count_t cnt_o
);

    dcp_pkg::dcp_front_state_t st;
    dcp_pkg::dcp_front_state_t next_st;

    // ==========================================================
    // Sync, sampling and accumulation
    always_comb begin
        next_st = st;
        next_st.sync = {st.sync[0], pres_i};
        if (tick_i) begin
            next_st.last = st.sync[1];
            // Vehicle arrival: presence rises between samples
            if (st.sync[1] && !st.last) begin
                next_st.cnt.vol = st.cnt.vol + `DCP_CNT_W'(1);
            end
            // Occupancy: one count per occupied sample
            if (st.sync[1]) begin
                next_st.cnt.occ = st.cnt.occ + `DCP_CNT_W'(1);
            end
        end
    end

    // Registers, never cleared by a report
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st.sync <= 2'h0;
            st.last <= 1'b0;
            st.cnt.vol <= `DCP_CNT_RST;
            st.cnt.occ <= `DCP_CNT_RST;
        end else begin
            st <= next_st;
        end
    end

    assign cnt_o = st.cnt;

endmodule : dcp_chan_front

// ---- src/dcp_map.svh ----
`ifndef DCP_MAP_SVH
`define DCP_MAP_SVH

// ==========================================================
// Sizes
`define DCP_NUM_CH 8
`define DCP_CNT_W 14
`define DCP_CNT_MIN_W 14
`define DCP_IDX_W 3

// ==========================================================
// Timing
`define DCP_CLK_NS 20
`define DCP_SAMPLE_MS 10
`define DCP_SAMPLE_CYC ((`DCP_SAMPLE_MS * 1000000) / `DCP_CLK_NS)
`define DCP_REPORT_S 300
`define DCP_REPORT_TICKS ((`DCP_REPORT_S * 1000) / `DCP_SAMPLE_MS)

// ==========================================================
// Reset values
`define DCP_CNT_RST 14'h0000
`define DCP_THR_RST 14'h0000
`define DCP_MASK_ALL 8'hff

`endif

// ---- src/dcp_pkg.sv ----
`include "dcp_map.svh"

package dcp_pkg;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [`DCP_CNT_W-1:0] vol;
        logic [`DCP_CNT_W-1:0] occ;
    } dcp_count_t;

    typedef struct packed {
        logic valid;
        logic last;
        logic cmd;
        logic sel;
        logic [`DCP_IDX_W-1:0] chan;
        logic [`DCP_CNT_W-1:0] vol;
        logic [`DCP_CNT_W-1:0] occ;
    } dcp_report_t;

    typedef struct packed {
        logic [`DCP_CNT_W-1:0] vol_low_outer;
        logic [`DCP_CNT_W-1:0] vol_low_inner;
        logic [`DCP_CNT_W-1:0] vol_high_inner;
        logic [`DCP_CNT_W-1:0] vol_high_outer;
        logic [`DCP_CNT_W-1:0] occ_low_outer;
        logic [`DCP_CNT_W-1:0] occ_low_inner;
        logic [`DCP_CNT_W-1:0] occ_high_inner;
        logic [`DCP_CNT_W-1:0] occ_high_outer;
    } dcp_thr_t;

    // ==========================================================
    // States
    typedef enum logic {
        DCP_IDLE,
        DCP_SEND
    } dcp_rpt_state_t;

    typedef struct packed {
        logic [1:0] sync;
        logic last;
        dcp_count_t cnt;
    } dcp_front_state_t;

    typedef struct packed {
        logic [31:0] sample_cnt;
        logic [31:0] period_cnt;
        logic tick;
        logic [2:0] cmd_sync;
        logic per_pend;
        logic cmd_pend;
        dcp_rpt_state_t state;
        logic [`DCP_IDX_W-1:0] idx;
        logic [`DCP_NUM_CH-1:0] mask;
        logic cmd_cause;
        logic busy;
        dcp_report_t rpt;
        dcp_thr_t thr;
        logic thr_reject;
    } dcp_main_state_t;

endpackage : dcp_pkg

// ---- src/dcp_preproc.sv ----
`timescale 1ns/1ps
`include "dcp_map.svh"

module dcp_preproc #(
    parameter int NUM_CH = `DCP_NUM_CH,
    parameter int SAMPLE_CYCLES = `DCP_SAMPLE_CYC,
    parameter int REPORT_TICKS = `DCP_REPORT_TICKS
) (
    // Clock and reset
    input wire logic CLOCK_I,
    input wire logic RESET_N_I,
    // Detector presence pins
    input wire logic [`DCP_NUM_CH-1:0] PRESENCE_I,
    // Central command pin and detector selection
    input wire logic XMIT_CMD_I,
    input wire logic [`DCP_NUM_CH-1:0] CHAN_SEL_I,
    // Threshold set from the central system
    input wire logic THR_LOAD_I,
    input dcp_pkg::dcp_thr_t THR_I,
    // Report stream
    output dcp_pkg::dcp_report_t RPT_O,
    output logic BUSY_O,
    // Held thresholds
    output dcp_pkg::dcp_thr_t THR_O,
    output logic THR_REJECT_O
);

    // ==========================================================
    // Elaboration checks
    // Refuse sizes the index and counters cannot serve
    if (NUM_CH < 1 || NUM_CH > `DCP_NUM_CH) begin : g_bad_ch
        $error("NUM_CH out of range");
    end
    if (SAMPLE_CYCLES < 1 || REPORT_TICKS < 1) begin : g_bad_time
        $error("Timing counts must be positive");
    end
    if (`DCP_CNT_W < `DCP_CNT_MIN_W) begin : g_bad_cnt
        $error("Counters below four decimal digits");
    end

    dcp_pkg::dcp_main_state_t st;
    dcp_pkg::dcp_main_state_t next_st;
    dcp_pkg::dcp_count_t counts [NUM_CH];

    // ==========================================================
    // Channel front ends
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            dcp_chan_front u_front (
                .clk_i(CLOCK_I),
                .rst_n_i(RESET_N_I),
                .pres_i(PRESENCE_I[g]),
                .tick_i(st.tick),
                .cnt_o(counts[g])
            );
        end
    endgenerate

    // ==========================================================
    // Threshold ordering check
    function automatic logic thr_ok(input dcp_pkg::dcp_thr_t t);
        thr_ok = (t.vol_low_outer < t.vol_low_inner)
            && (t.vol_high_inner < t.vol_high_outer)
            && (t.vol_low_inner <= t.vol_high_inner)
            && (t.occ_low_outer < t.occ_low_inner)
            && (t.occ_high_inner < t.occ_high_outer)
            && (t.occ_low_inner <= t.occ_high_inner);
    endfunction : thr_ok

    logic per_event;
    logic cmd_event;
    logic start;
    logic start_cmd;
    logic last_slot;
    dcp_pkg::dcp_count_t cur;

    // ==========================================================
    // Event decode
    always_comb begin
        per_event = st.tick
            && (st.period_cnt == 32'(REPORT_TICKS - 1));
        cmd_event = st.cmd_sync[1] && !st.cmd_sync[2];
        start = (st.state == dcp_pkg::DCP_IDLE)
            && (st.per_pend || st.cmd_pend);
        start_cmd = start && st.cmd_pend;
        last_slot = (st.idx == `DCP_IDX_W'(NUM_CH - 1));
        cur = counts[st.idx];
    end

    // ==========================================================
    // Next state
    always_comb begin
        next_st = st;
        next_st.rpt.valid = 1'b0;
        next_st.rpt.last = 1'b0;
        // Sample strobe
        next_st.tick = 1'b0;
        if (st.sample_cnt == 32'(SAMPLE_CYCLES - 1)) begin
            next_st.sample_cnt = 32'h0;
            next_st.tick = 1'b1;
        end else begin
            next_st.sample_cnt = st.sample_cnt + 32'h1;
        end
        // Report period in sample ticks
        if (st.tick) begin
            if (per_event) begin
                next_st.period_cnt = 32'h0;
            end else begin
                next_st.period_cnt = st.period_cnt + 32'h1;
            end
        end
        // Command pin sync and edge
        next_st.cmd_sync = {st.cmd_sync[1:0], XMIT_CMD_I};
        // Pending flags, a new event wins over the clear
        next_st.per_pend = (st.per_pend && !(start && !start_cmd))
            || per_event;
        next_st.cmd_pend = (st.cmd_pend && !start_cmd)
            || cmd_event;
        case (st.state)
            dcp_pkg::DCP_IDLE: begin
                // Busy drops one cycle after the last record
                next_st.busy = 1'b0;
                if (start) begin
                    next_st.state = dcp_pkg::DCP_SEND;
                    next_st.busy = 1'b1;
                    next_st.idx = `DCP_IDX_W'(0);
                    next_st.cmd_cause = start_cmd;
                    // Command reports flag the chosen detectors
                    next_st.mask = start_cmd ? CHAN_SEL_I
                        : `DCP_MASK_ALL;
                end
            end
            dcp_pkg::DCP_SEND: begin
                // Live accumulations, counters untouched
                next_st.rpt.valid = 1'b1;
                next_st.rpt.chan = st.idx;
                next_st.rpt.vol = cur.vol;
                next_st.rpt.occ = cur.occ;
                next_st.rpt.cmd = st.cmd_cause;
                next_st.rpt.sel = st.mask[st.idx];
                next_st.rpt.last = last_slot;
                // Back to idle after the final channel
                if (last_slot) begin
                    next_st.state = dcp_pkg::DCP_IDLE;
                end else begin
                    next_st.idx = st.idx + `DCP_IDX_W'(1);
                end
            end
            default: begin
                next_st.state = dcp_pkg::DCP_IDLE;
            end
        endcase
        // Threshold load, refused unless ordered
        if (THR_LOAD_I) begin
            if (thr_ok(THR_I)) begin
                next_st.thr = THR_I;
                next_st.thr_reject = 1'b0;
            end else begin
                next_st.thr_reject = 1'b1;
            end
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge CLOCK_I) begin
        if (!RESET_N_I) begin
            st.sample_cnt <= 32'h0;
            st.period_cnt <= 32'h0;
            st.tick <= 1'b0;
            st.cmd_sync <= 3'h0;
            st.per_pend <= 1'b0;
            st.cmd_pend <= 1'b0;
            st.state <= dcp_pkg::DCP_IDLE;
            st.idx <= `DCP_IDX_W'(0);
            st.mask <= `DCP_MASK_ALL;
            st.cmd_cause <= 1'b0;
            st.busy <= 1'b0;
            st.rpt.valid <= 1'b0;
            st.rpt.last <= 1'b0;
            st.rpt.cmd <= 1'b0;
            st.rpt.sel <= 1'b0;
            st.rpt.chan <= `DCP_IDX_W'(0);
            st.rpt.vol <= `DCP_CNT_RST;
            st.rpt.occ <= `DCP_CNT_RST;
            st.thr.vol_low_outer <= `DCP_THR_RST;
            st.thr.vol_low_inner <= `DCP_THR_RST;
            st.thr.vol_high_inner <= `DCP_THR_RST;
            st.thr.vol_high_outer <= `DCP_THR_RST;
            st.thr.occ_low_outer <= `DCP_THR_RST;
            st.thr.occ_low_inner <= `DCP_THR_RST;
            st.thr.occ_high_inner <= `DCP_THR_RST;
            st.thr.occ_high_outer <= `DCP_THR_RST;
            st.thr_reject <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs
    assign RPT_O = st.rpt;
    assign BUSY_O = st.busy;
    // Held threshold set and refusal flag
    assign THR_O = st.thr;
    assign THR_REJECT_O = st.thr_reject;

endmodule : dcp_preproc

// ---- testbench/dcp_central.sv ----
`timescale 1ns/1ps
`include "dcp_map.svh"
// ====================
// Central system: command pin and report intake
module dcp_central (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Report stream in, command out
    input wire dcp_pkg::dcp_report_t rpt_i,
    output logic xmit_o,
    // Threshold bands in force
    input wire dcp_pkg::dcp_thr_t thr_i
);
    logic [`DCP_CNT_W-1:0] vol [8] = '{default: 14'h0};
    logic [`DCP_CNT_W-1:0] occ [8];
    logic [`DCP_CNT_W-1:0] dvol [8];
    logic [`DCP_CNT_W-1:0] pvol [8] = '{default: 14'h0};
    logic [`DCP_CNT_W-1:0] pocc [8] = '{default: 14'h0};
    logic [`DCP_CNT_W-1:0] iv, io;
    logic [1:0] gv, go;
    logic [1:0] stat [8];
    logic [7:0] seen = 8'h00;
    logic [7:0] sel;
    logic cmd;
    int nrep = 0;
    initial xmit_o = 1'b0;
    // Two-band grade: 0 normal, 1 marginal, 2 unacceptable
    function automatic logic [1:0] grade(input logic [`DCP_CNT_W-1:0] x,
        lo_o, lo_i, hi_i, hi_o);
        if (x >= lo_i && x <= hi_i) begin
            grade = 2'h0;
        end else if (x >= lo_o && x <= hi_o) begin
            grade = 2'h1;
        end else begin
            grade = 2'h2;
        end
    endfunction : grade
    // Interval since the last periodic record, then its grades
    always_comb begin
        iv = rpt_i.vol - pvol[rpt_i.chan];
        io = rpt_i.occ - pocc[rpt_i.chan];
        gv = grade(iv, thr_i.vol_low_outer, thr_i.vol_low_inner,
            thr_i.vol_high_inner, thr_i.vol_high_outer);
        go = grade(io, thr_i.occ_low_outer, thr_i.occ_low_inner,
            thr_i.occ_high_inner, thr_i.occ_high_outer);
    end
    // Keep each record, interval wraps with counter width
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            nrep <= 0;
        end else if (rpt_i.valid) begin
            dvol[rpt_i.chan] <= rpt_i.vol - vol[rpt_i.chan];
            vol[rpt_i.chan] <= rpt_i.vol;
            occ[rpt_i.chan] <= rpt_i.occ;
            sel[rpt_i.chan] <= rpt_i.sel;
            cmd <= rpt_i.cmd;
            seen[rpt_i.chan] <= 1'b1;
            // Periodic records: grade the interval of one report period
            if (!rpt_i.cmd) begin
                pvol[rpt_i.chan] <= rpt_i.vol;
                pocc[rpt_i.chan] <= rpt_i.occ;
                stat[rpt_i.chan] <= (gv > go) ? gv : go;
            end
            // Channel missing from a report marks a failure
            if (rpt_i.last) begin
                nrep <= nrep + 1;
                seen <= 8'h00;
                for (int i = 0; i < 8; i++) begin
                    if (!seen[i] && i != int'(rpt_i.chan)) begin
                        stat[i] <= 2'h3;
                    end
                end
            end
        end
    end
    // Command held past the pin synchroniser
    task automatic send_cmd();
        @(posedge clk_i);
        #1 xmit_o = 1'b1;
        repeat (4) @(posedge clk_i);
        #1 xmit_o = 1'b0;
    endtask : send_cmd
endmodule : dcp_central

// ---- testbench/dcp_preproc_assertions.sv ----
`timescale 1ns/1ps
`include "dcp_map.svh"
// ====================
// Report stream and threshold checks
module dcp_preproc_assertions #(
    parameter int NUM_CH = 8,
    parameter int SAMPLE_CYCLES = 4,
    parameter int REPORT_TICKS = 5
) (
    // Clock and reset
    input wire logic CLOCK_I,
    input wire logic RESET_N_I,
    // Inputs
    input wire logic [`DCP_NUM_CH-1:0] PRESENCE_I,
    input wire logic XMIT_CMD_I,
    input wire logic [`DCP_NUM_CH-1:0] CHAN_SEL_I,
    input wire logic THR_LOAD_I,
    input wire dcp_pkg::dcp_thr_t THR_I,
    // Outputs
    input wire dcp_pkg::dcp_report_t RPT_O,
    input wire logic BUSY_O,
    input wire dcp_pkg::dcp_thr_t THR_O,
    input wire logic THR_REJECT_O
);
    localparam int LIM = SAMPLE_CYCLES * REPORT_TICKS + 40;
    logic [31:0] gap;
    default clocking @(posedge CLOCK_I);
    endclocking
    default disable iff (!RESET_N_I);
    // Cycles since the last record
    always_ff @(posedge CLOCK_I) begin
        if (!RESET_N_I || RPT_O.valid) gap <= 32'h0;
        else gap <= gap + 32'h1;
    end
    property p_first;
        $rose(RPT_O.valid) |-> RPT_O.chan == 3'h0 && BUSY_O;
    endproperty
    a_first: assert property (p_first) else $error("first record");
    property p_next;
        RPT_O.valid && !RPT_O.last |=> RPT_O.valid && RPT_O.cmd ==
            $past(RPT_O.cmd) && RPT_O.chan == $past(RPT_O.chan) + 3'h1;
    endproperty
    a_next: assert property (p_next) else $error("record order");
    property p_last;
        RPT_O.last |-> RPT_O.valid && 32'(RPT_O.chan) == NUM_CH - 1;
    endproperty
    a_last: assert property (p_last) else $error("last record");
    property p_gap;
        RPT_O.last |=> !RPT_O.valid;
    endproperty
    a_gap: assert property (p_gap) else $error("no idle cycle");
    property p_cmd;
        $rose(XMIT_CMD_I) |-> ##[5:40] RPT_O.valid && RPT_O.cmd;
    endproperty
    a_cmd: assert property (p_cmd) else $error("command ignored");
    property p_per;
        gap <= LIM;
    endproperty
    a_per: assert property (p_per) else $error("periodic late");
    property p_psel;
        RPT_O.valid && !RPT_O.cmd |-> RPT_O.sel;
    endproperty
    a_psel: assert property (p_psel) else $error("periodic sel");
    property p_take;
        THR_LOAD_I |=> THR_REJECT_O || THR_O == $past(THR_I);
    endproperty
    a_take: assert property (p_take) else $error("load lost");
    property p_rej;
        THR_LOAD_I && (THR_I.vol_low_outer >= THR_I.vol_low_inner ||
            THR_I.occ_high_outer <= THR_I.occ_high_inner)
            |=> THR_REJECT_O && $stable(THR_O);
    endproperty
    a_rej: assert property (p_rej) else $error("bad set taken");
    property p_hold;
        !THR_LOAD_I |=> $stable(THR_O) && $stable(THR_REJECT_O);
    endproperty
    a_hold: assert property (p_hold) else $error("thr moved");
    c_cmd: cover property (RPT_O.last && RPT_O.cmd);
    c_per: cover property (RPT_O.last && !RPT_O.cmd);
    c_rej: cover property ($rose(THR_REJECT_O));
endmodule : dcp_preproc_assertions

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
`include "dcp_map.svh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
    miscompares++; $display("Error %s exp %h got %h", nm, ex, got); end end
// ====================
// Bench top
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] pres = 8'h00;
    logic [7:0] sel = 8'hff;
    logic load = 1'b0;
    dcp_pkg::dcp_thr_t thr = '0;
    dcp_pkg::dcp_report_t rpt;
    dcp_pkg::dcp_thr_t thr_q;
    logic busy, rej, xmit;
    int miscompares = 0;
    int compares = 0;
    dcp_preproc #(.SAMPLE_CYCLES(4), .REPORT_TICKS(50)) dut_u (
        .CLOCK_I(clk), .RESET_N_I(rst_n), .PRESENCE_I(pres),
        .XMIT_CMD_I(xmit), .CHAN_SEL_I(sel), .THR_LOAD_I(load),
        .THR_I(thr), .RPT_O(rpt), .BUSY_O(busy), .THR_O(thr_q),
        .THR_REJECT_O(rej));
    dcp_central cen_u (.clk_i(clk), .rst_n_i(rst_n), .rpt_i(rpt),
        .xmit_o(xmit), .thr_i(thr_q));
    initial begin
        forever #10 clk = ~clk;
    end
    // Verdict and stop
    task automatic end_sim();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim
    // Bounded wait for report number n+1 to end
    task automatic wait_rep(input int n);
        for (int i = 0; i < 400 && cen_u.nrep <= n; i++) @(posedge clk);
        #1;
        `CHK("report_seen", 1'b1, 1'(cen_u.nrep > n))
        if (cen_u.nrep <= n) end_sim();
    endtask : wait_rep
    task automatic t_count();
        wait_rep(cen_u.nrep);
        for (int v = 0; v < 8; v++) begin
            pres = 8'hff << v;
            repeat (8) @(posedge clk);
            #1 pres = 8'h00;
            repeat (8) @(posedge clk);
            #1;
        end
        cen_u.send_cmd();
        wait_rep(cen_u.nrep);
        `CHK("cmd", 1'b1, cen_u.cmd)
        for (int i = 0; i < 8; i++) begin
            `CHK("vol", 14'(i + 1), cen_u.vol[i])
            `CHK("occ", 14'(2 * i + 2), cen_u.occ[i])
        end
    endtask : t_count
    task automatic t_again();
        int n;
        n = cen_u.nrep;
        cen_u.send_cmd();
        cen_u.send_cmd();
        wait_rep(n + 1);
        for (int i = 0; i < 8; i++) begin
            `CHK("dvol", 14'h0, cen_u.dvol[i])
            `CHK("vol_kept", 14'(i + 1), cen_u.vol[i])
        end
    endtask : t_again
    task automatic t_sel();
        wait_rep(cen_u.nrep);
        sel = 8'h5a;
        cen_u.send_cmd();
        wait_rep(cen_u.nrep);
        `CHK("sel", 8'h5a, cen_u.sel)
        sel = 8'h00;
        wait_rep(cen_u.nrep);
        `CHK("per_cmd", 1'b0, cen_u.cmd)
        `CHK("per_sel", 8'hff, cen_u.sel)
    endtask : t_sel
    task automatic load_thr(input dcp_pkg::dcp_thr_t v, input logic r);
        dcp_pkg::dcp_thr_t keep;
        @(posedge clk);
        #1 keep = r ? thr_q : v;
        thr = v;
        load = 1'b1;
        @(posedge clk);
        #1 load = 1'b0;
        `CHK("thr_reject", r, rej)
        `CHK("thr_held", keep, thr_q)
    endtask : load_thr
    // Intervals of 50 sample ticks graded against the loaded bands
    task automatic t_grade();
        logic [1:0] exp [8] = '{2'h2, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2,
            2'h2, 2'h2};
        wait_rep(cen_u.nrep);
        for (int v = 0; v < 4; v++) begin
            pres = 8'hfe << v;
            repeat (8) @(posedge clk);
            #1 pres = 8'h00;
            repeat (8) @(posedge clk);
            #1;
        end
        wait_rep(cen_u.nrep);
        for (int i = 0; i < 8; i++) begin
            `CHK("stat", exp[i], cen_u.stat[i])
        end
    endtask : t_grade
    initial begin
        repeat (3) @(posedge clk);
        #1 rst_n = 1'b1;
        @(posedge clk);
        #1;
        `CHK("reset_out", 1'b0, |{rpt, busy, thr_q, rej})
        t_count();
        t_again();
        t_sel();
        load_thr({14'h0a, 14'h14, 14'h14, 14'h28, 14'h04, 14'h0c,
            14'h30, 14'h40}, 1'b0);
        load_thr({14'h14, 14'h14, 14'h1e, 14'h28, 56'h0}, 1'b1);
        load_thr({14'h01, 14'h02, 14'h03, 14'h04, 14'h01, 14'h02,
            14'h04, 14'h04}, 1'b1);
        load_thr({14'h01, 14'h02, 14'h03, 14'h04, 14'h01, 14'h02,
            14'h03, 14'h05}, 1'b0);
        t_grade();
        end_sim();
    end
endmodule : tb_top
bind dcp_preproc dcp_preproc_assertions #(.NUM_CH(NUM_CH),
    .SAMPLE_CYCLES(SAMPLE_CYCLES), .REPORT_TICKS(REPORT_TICKS)) chk_u (
    .CLOCK_I, .RESET_N_I, .PRESENCE_I, .XMIT_CMD_I, .CHAN_SEL_I,
    .THR_LOAD_I, .THR_I, .RPT_O, .BUSY_O, .THR_O, .THR_REJECT_O);
